// >>> logic/gpc_pkg.sv
// Package of constants and reset values for the general purpose port block
//
// Overview of operation
// - Port read gives pins, write goes to latch
// - Latch write equals port write; reads stored latch
// - Writes merge sampled pins with masked data
// - Direction one tristates, zero drives latch value
// - Analog pins other than master clear read zero through port path
// - Analog select disables digital input, reads zero except master clear pin
// - Analog select leaves digital output working
// - Analog select resets analog; software clears it
// - Pull-up enable bit controls each pin's pull-up
// - Threshold bit picks Schmitt or TTL input
// - Slew bit set limits pin slew rate
// - Open-drain bit set makes output sink only
// - Per-pin rising or falling edge raises event
// - Enabled I2C pad peripherals read I2C levels
// - After reset all pins are inputs, driver off
// - Peripheral owns output, pin still readable
// - Analog output forces digital driver off
// - Config, analog out, then port or peripheral
// - Master clear disabled makes input-only port pin
// - Master clear bit read-only, reads one if enabled
// - Pull-up forced by master clear or low-voltage programming
package gpc_pkg;

    localparam int unsigned   PIN_COUNT      = 8;
    localparam int unsigned   CLEAR_PIN_BIT  = 3;
    localparam int unsigned   SYNC_STAGES    = 2;

    // Values after reset
    localparam logic [7:0]    LATCH_RESET    = 8'h00;
    localparam logic [7:0]    DIR_RESET      = 8'hFF;
    localparam logic [7:0]    ANALOG_RESET   = 8'hFF;
    localparam logic [7:0]    PULLUP_RESET   = 8'h00;
    localparam logic [7:0]    THRESH_RESET   = 8'hFF;
    localparam logic [7:0]    SLEW_RESET     = 8'hFF;
    localparam logic [7:0]    DRAIN_RESET    = 8'h00;
    localparam logic [7:0]    ZERO_BYTE      = 8'h00;

    // Single-bit mask of the master clear pin inside the port
    localparam logic [7:0]    CLEAR_PIN_MASK = 8'h08;

endpackage

// >>> logic/gpc_port.sv
// Eight-pin general purpose port: latch, direction, input paths and pin ownership
`timescale 1ns/100ps
module gpc_port
    import gpc_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Software register writes, one strobe per register
    input  wire logic       wr_port_value,
    input  wire logic       wr_output_latch,
    input  wire logic       wr_direction_ctrl,
    input  wire logic       wr_analog_select,
    input  wire logic       wr_pull_up_enable,
    input  wire logic       wr_input_threshold_sel,
    input  wire logic       wr_slew_limit,
    input  wire logic       wr_open_drain_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic [7:0] wr_mask,
    // Software register readback
    output logic      [7:0] port_pin_value,
    output logic      [7:0] output_latch,
    output logic      [7:0] direction_ctrl,
    output logic      [7:0] analog_select,
    output logic      [7:0] pull_up_enable,
    output logic      [7:0] input_threshold_sel,
    output logic      [7:0] slew_limit,
    output logic      [7:0] open_drain_sel,
    // Configuration bits
    input  wire logic       master_clear_enable,
    input  wire logic       low_voltage_prog,
    input  wire logic [7:0] cfg_pin_own,
    // Pin pad inputs, asynchronous
    input  wire logic [7:0] pin_st_in,
    input  wire logic [7:0] pin_ttl_in,
    input  wire logic [7:0] pin_i2c_in,
    // Pin pad drive
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    output logic      [7:0] pad_pull_up,
    output logic      [7:0] pad_slew_limit,
    output logic      [7:0] pad_open_drain,
    // Peripherals
    input  wire logic [7:0] periph_en,
    input  wire logic [7:0] periph_out,
    input  wire logic [7:0] i2c_pad_ctrl,
    input  wire logic [7:0] analog_out_en,
    output logic      [7:0] periph_in,
    // Master clear reset request
    output logic            master_clear_req,
    // Edge events
    input  wire logic [7:0] edge_rise_en,
    input  wire logic [7:0] edge_fall_en,
    output logic      [7:0] edge_flags,
    output logic            edge_change_irq
);

    logic [7:0] std_level;
    logic [7:0] std_sync;
    logic [7:0] i2c_sync;
    logic [7:0] std_prev;
    logic [7:0] pins_read;
    logic [7:0] latch_merge;
    logic [7:0] gp_drive;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_periph_in;
    logic [7:0] next_pull_up;
    logic [7:0] next_edges;
    logic       clear_pull_force;

    // Threshold mux ahead of the synchroniser; switching it live can glitch
    assign std_level = (input_threshold_sel & pin_st_in)
                     | (~input_threshold_sel & pin_ttl_in);

    gpc_sync #(
        .WIDTH    (PIN_COUNT)
    ) u_sync_std (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (std_level),
        .sync_out (std_sync)
    );

    gpc_sync #(
        .WIDTH    (PIN_COUNT)
    ) u_sync_i2c (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in (pin_i2c_in),
        .sync_out (i2c_sync)
    );

    // Port read path: analog pins gated to zero, master clear reads one when enabled
    always_comb
    begin
        pins_read = std_sync & ~analog_select;
        // The master clear position has no analog buffer, so analog select is ignored there
        if (master_clear_enable)
            pins_read[CLEAR_PIN_BIT] = 1'b1;
        else
            pins_read[CLEAR_PIN_BIT] = std_sync[CLEAR_PIN_BIT];
    end

    // Write merges the sampled pins with the masked data bits
    assign latch_merge = (pins_read & ~wr_mask) | (wr_data & wr_mask);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            port_pin_value <= ZERO_BYTE;
        else
            port_pin_value <= pins_read;
    end

    // Output latch; the master clear position has no latch bit
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            output_latch <= LATCH_RESET;
        else if (wr_port_value || wr_output_latch)
            output_latch <= latch_merge & ~CLEAR_PIN_MASK;
    end

    // Direction; master clear position is fixed as input
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            direction_ctrl <= DIR_RESET;
        else if (wr_direction_ctrl)
            direction_ctrl <= wr_data | CLEAR_PIN_MASK;
    end

    // Analog select comes up analog so the input buffers start disabled
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            analog_select <= ANALOG_RESET;
        else if (wr_analog_select)
            analog_select <= wr_data;
    end

    // Remaining per-pin pad settings
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pull_up_enable      <= PULLUP_RESET;
            input_threshold_sel <= THRESH_RESET;
            slew_limit          <= SLEW_RESET;
            open_drain_sel      <= DRAIN_RESET;
        end
        else
        begin
            if (wr_pull_up_enable)
                pull_up_enable <= wr_data;
            if (wr_input_threshold_sel)
                input_threshold_sel <= wr_data;
            if (wr_slew_limit)
                slew_limit <= wr_data;
            if (wr_open_drain_sel)
                open_drain_sel <= wr_data;
        end
    end

    // Pin ownership: config bits, then analog out, then port or peripheral
    always_comb
    begin
        gp_drive = ~direction_ctrl;
        gp_drive = gp_drive & ~analog_out_en;
        gp_drive = gp_drive & ~cfg_pin_own;
        gp_drive[CLEAR_PIN_BIT] = 1'b0;
        // Analog select is not consulted here on purpose
        next_pin_out = (periph_en & periph_out)
                     | (~periph_en & output_latch);
        // Open drain only enables the driver while pulling low
        next_pin_oe = gp_drive & ~(open_drain_sel & next_pin_out);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out <= ZERO_BYTE;
            pin_oe  <= ZERO_BYTE;
        end
        else
        begin
            pin_out <= next_pin_out;
            pin_oe  <= next_pin_oe;
        end
    end

    // Pull-up off while driving; master clear pull-up forced by configuration
    assign clear_pull_force = (master_clear_enable && !low_voltage_prog) || low_voltage_prog;

    always_comb
    begin
        next_pull_up = pull_up_enable & ~next_pin_oe;
        if (clear_pull_force)
            next_pull_up[CLEAR_PIN_BIT] = 1'b1;
    end

    // Pad settings and peripheral inputs registered for clean outputs
    always_comb
    begin
        next_periph_in = (periph_en & i2c_pad_ctrl & i2c_sync)
                       | (~(periph_en & i2c_pad_ctrl) & std_sync);
        next_periph_in = next_periph_in & ~analog_select;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad_pull_up      <= PULLUP_RESET;
            pad_slew_limit   <= SLEW_RESET;
            pad_open_drain   <= DRAIN_RESET;
            periph_in        <= ZERO_BYTE;
            master_clear_req <= 1'b0;
        end
        else
        begin
            pad_pull_up      <= next_pull_up;
            pad_slew_limit   <= slew_limit;
            pad_open_drain   <= open_drain_sel;
            periph_in        <= next_periph_in;
            master_clear_req <= master_clear_enable && !std_sync[CLEAR_PIN_BIT];
        end
    end

    // Edge detection on the synchronised, analog-gated levels
    assign next_edges = (edge_rise_en & pins_read & ~std_prev)
                      | (edge_fall_en & ~pins_read & std_prev);

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            std_prev        <= ZERO_BYTE;
            edge_flags      <= ZERO_BYTE;
            edge_change_irq <= 1'b0;
        end
        else
        begin
            std_prev        <= pins_read;
            edge_flags      <= next_edges;
            edge_change_irq <= |next_edges;
        end
    end

    // Checks on the design's own outputs
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_latch_merge_write: assert property (
        (wr_port_value || wr_output_latch) |=> output_latch ==
            ((($past(pins_read) & ~$past(wr_mask)) | ($past(wr_data) & $past(wr_mask)))
             & ~CLEAR_PIN_MASK))
        else $error("latch did not take merged write");

    a_analog_read_zero: assert property (
        1'b1 |=> (port_pin_value & $past(analog_select) & ~CLEAR_PIN_MASK) == ZERO_BYTE)
        else $error("analog pin read nonzero");

    a_driver_off_blocked: assert property (
        1'b1 |=> (pin_oe & $past(direction_ctrl | analog_out_en | cfg_pin_own)) == ZERO_BYTE)
        else $error("driver on for blocked pin");

    a_open_drain_sink: assert property (
        1'b1 |=> (pin_oe & pin_out & $past(open_drain_sel)) == ZERO_BYTE)
        else $error("open drain pin sourcing");

    a_clear_pin_one: assert property (
        master_clear_enable |=> port_pin_value[CLEAR_PIN_BIT])
        else $error("master clear bit not one");

    a_clear_pin_pull: assert property (
        low_voltage_prog |=> pad_pull_up[CLEAR_PIN_BIT])
        else $error("master clear pull-up not forced");

    a_edge_rise_event: assert property (
        (edge_rise_en[0] && pins_read[0] && !std_prev[0]) |=> edge_flags[0] && edge_change_irq)
        else $error("rising edge missed");

    a_periph_owns_out: assert property (
        1'b1 |=> ((pin_out ^ $past(periph_out)) & $past(periph_en)) == ZERO_BYTE)
        else $error("peripheral not driving pin");

    a_periph_in_analog: assert property (
        1'b1 |=> (periph_in & $past(analog_select)) == ZERO_BYTE)
        else $error("analog pin leaks to peripheral");

    // Read path and register shape
    a_port_read_pins: assert property (
        1'b1 |=> ((port_pin_value ^ $past(std_sync)) & ~$past(analog_select)
                  & ~CLEAR_PIN_MASK) == ZERO_BYTE)
        else $error("port read differs from pins");

    a_clear_pin_fixed: assert property (
        1'b1 |-> direction_ctrl[CLEAR_PIN_BIT] && !output_latch[CLEAR_PIN_BIT])
        else $error("master clear pin gained latch or driver bit");

    // Pad drive and ownership
    a_clear_pin_input: assert property (
        1'b1 |-> !pin_oe[CLEAR_PIN_BIT])
        else $error("master clear pin driven");

    a_driver_on_digital: assert property (
        1'b1 |=> ((pin_oe ^ $past(~direction_ctrl & ~analog_out_en & ~cfg_pin_own))
                  & ~$past(open_drain_sel) & ~CLEAR_PIN_MASK) == ZERO_BYTE)
        else $error("digital driver state wrong");

    a_latch_drives_pin: assert property (
        1'b1 |=> ((pin_out ^ $past(output_latch)) & ~$past(periph_en)) == ZERO_BYTE)
        else $error("pin not driven from latch");

    a_pull_off_driving: assert property (
        1'b1 |-> (pad_pull_up & pin_oe) == ZERO_BYTE)
        else $error("pull-up on while driving");

    a_pull_follows_en: assert property (
        1'b1 |=> ((pad_pull_up ^ $past(pull_up_enable)) & ~pin_oe & ~CLEAR_PIN_MASK)
                 == ZERO_BYTE)
        else $error("pull-up does not follow enable");

    a_slew_follows: assert property (
        1'b1 |=> pad_slew_limit == $past(slew_limit))
        else $error("slew setting not at pad");

    a_drain_follows: assert property (
        1'b1 |=> pad_open_drain == $past(open_drain_sel))
        else $error("open-drain setting not at pad");

    a_i2c_level_in: assert property (
        1'b1 |=> ((periph_in ^ $past(i2c_sync))
                  & $past(periph_en & i2c_pad_ctrl & ~analog_select)) == ZERO_BYTE)
        else $error("peripheral not reading I2C level");

    // Events
    a_edge_fall_event: assert property (
        (edge_fall_en[1] && !pins_read[1] && std_prev[1]) |=> edge_flags[1] && edge_change_irq)
        else $error("falling edge missed");

    a_irq_is_or: assert property (
        1'b1 |-> edge_change_irq == (|edge_flags))
        else $error("event output not the OR of flags");

endmodule

// >>> logic/gpc_sync.sv
// Two-flop synchroniser for a bus of independent asynchronous levels
`timescale 1ns/100ps
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int unsigned WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// >>> verif/gpc_pin_model.sv
// Pad and outside-world model: resolves each pin level from every driver
`timescale 1ns/100ps
module gpc_pin_model
(
    // Clock
    input  wire logic       ref_clk,
    // Pad drive from the port
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pad_pull_up,
    // Outside drivers and threshold skew
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] skew,
    // Pad receivers
    output logic      [7:0] pin_st_in,
    output logic      [7:0] pin_ttl_in,
    output logic      [7:0] pin_i2c_in
);
    logic [7:0] lvl;
    logic [7:0] last = 8'h00;

    // Port driver wins, then outside driver, then pull-up; a bare pad drifts
    assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
               | (~pin_oe & ~ext_en & (pad_pull_up | ~last));
    // Skew moves the TTL trip point; the I2C trip point differs unless skewed
    assign pin_st_in  = lvl;
    assign pin_ttl_in = lvl ^ skew;
    assign pin_i2c_in = lvl ^ ~skew;

    // Floating pads never repeat the last level, so stale values cannot pass
    always @(posedge ref_clk)
        last <= lvl;
endmodule

// >>> verif/gpc_port_tb_top.sv
// Self-checking bench for the general purpose port block
`timescale 1ns/100ps
module gpc_port_tb_top
    import gpc_pkg::*;
;
    typedef struct {int k; logic [7:0] e;} gpc_note_t;
    localparam logic [7:0] IO_BITS = ~CLEAR_PIN_MASK;

    logic       ref_clk, reset_n, master_clear_enable, low_voltage_prog;
    logic       master_clear_req, edge_change_irq, chk;
    logic [7:0] wr_sel, wr_data, wr_mask, cfg_pin_own, periph_en, periph_out, i2c_pad_ctrl;
    logic [7:0] analog_out_en, edge_rise_en, edge_fall_en, ext_val, ext_en, skew;
    logic [7:0] port_pin_value, output_latch, direction_ctrl, analog_select, pull_up_enable;
    logic [7:0] input_threshold_sel, slew_limit, open_drain_sel, pin_out, pin_oe;
    logic [7:0] pad_pull_up, pad_slew_limit, pad_open_drain, periph_in, edge_flags;
    logic [7:0] pin_st_in, pin_ttl_in, pin_i2c_in;
    int         bad_count = 0;
    int         compares  = 0;
    int         cyc       = 0;
    gpc_note_t  notes[$];
    gpc_note_t  n;
    string      nm [16] = '{"port", "latch", "dir", "analog", "pullup", "thresh", "slew",
                            "drain", "oe", "out", "pad_pu", "per_in", "edges", "pad_slew",
                            "pad_od", "req_irq"};

    gpc_port gpc_port_inst (.ref_clk, .reset_n, .wr_port_value(wr_sel[0]),
        .wr_output_latch(wr_sel[1]), .wr_direction_ctrl(wr_sel[2]),
        .wr_analog_select(wr_sel[3]), .wr_pull_up_enable(wr_sel[4]),
        .wr_input_threshold_sel(wr_sel[5]), .wr_slew_limit(wr_sel[6]),
        .wr_open_drain_sel(wr_sel[7]), .wr_data, .wr_mask, .port_pin_value, .output_latch,
        .direction_ctrl, .analog_select, .pull_up_enable, .input_threshold_sel, .slew_limit,
        .open_drain_sel, .master_clear_enable, .low_voltage_prog, .cfg_pin_own, .pin_st_in,
        .pin_ttl_in, .pin_i2c_in, .pin_out, .pin_oe, .pad_pull_up, .pad_slew_limit,
        .pad_open_drain, .periph_en, .periph_out, .i2c_pad_ctrl, .analog_out_en, .periph_in,
        .master_clear_req, .edge_rise_en, .edge_fall_en, .edge_flags, .edge_change_irq);

    gpc_pin_model gpc_pin_model_inst (.ref_clk, .pin_out, .pin_oe, .pad_pull_up, .ext_val,
        .ext_en, .skew, .pin_st_in, .pin_ttl_in, .pin_i2c_in);

    // 200 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Output picked by note kind
    function automatic logic [7:0] obs(int k);
        logic [7:0] v [16];
        v = '{port_pin_value, output_latch, direction_ctrl, analog_select, pull_up_enable,
              input_threshold_sel, slew_limit, open_drain_sel, pin_oe, pin_out, pad_pull_up,
              periph_in, edge_flags, pad_slew_limit, pad_open_drain,
              {6'h00, edge_change_irq, master_clear_req}};
        return v[k];
    endfunction

    // Inputs move just after the edge so sampling never races
    task automatic tick(int c = 1);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    // One-cycle write strobe, then a spare cycle so strobes never abut
    task automatic wr(int r, logic [7:0] d, logic [7:0] m = 8'hFF);
        wr_sel = 8'(1 << r);
        wr_data = d;
        wr_mask = m;
        tick();
        wr_sel = 8'h00;
        tick();
    endtask

    // Queue a note; the monitor compares it at the coming falling edge
    task automatic expect_v(int k, logic [7:0] e);
        notes.push_back('{k, e});
        chk = 1'b1;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Monitor: outputs are settled mid-cycle
    always @(negedge ref_clk)
        if (chk)
        begin
            chk = 1'b0;
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                compares++;
                if (obs(n.k) !== n.e)
                begin
                    bad_count++;
                    $display("ERROR %s expected %h seen %h", nm[n.k], n.e, obs(n.k));
                end
            end
        end

    // Hang guard, far above the expected 140 or so cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            conclude();
        end
    end

    initial
    begin
        logic [7:0] r, d, v, w, m, p, q;
        {reset_n, master_clear_enable, low_voltage_prog, chk, wr_sel, wr_data, wr_mask} = '0;
        {cfg_pin_own, periph_en, periph_out, i2c_pad_ctrl, analog_out_en} = '0;
        {edge_rise_en, edge_fall_en, ext_val, ext_en, skew} = '0;
        r = 8'($urandom(76));
        tick(6);
        reset_n = 1'b1;
        tick();
        expect_v(1, 8'h00);
        expect_v(2, 8'hFF);
        expect_v(3, 8'hFF);
        expect_v(4, 8'h00);
        expect_v(5, 8'hFF);
        expect_v(6, 8'hFF);
        expect_v(7, 8'h00);
        expect_v(8, 8'h00);
        tick();
        wr(3, 8'h00);
        // Random latch and direction; outside drives every input pin
        for (int i = 0; i < 6; i++)
        begin
            {r, d, v, w, m} = {8'($urandom()), 8'($urandom()), 8'($urandom()),
                               8'($urandom()), 8'($urandom())};
            wr(1, r);
            wr(2, d);
            {ext_en, ext_val} = {d | CLEAR_PIN_MASK, v};
            tick(4);
            p = (~d & r & IO_BITS) | ((d | CLEAR_PIN_MASK) & v);
            expect_v(0, p);
            expect_v(11, p);
            expect_v(1, r & IO_BITS);
            expect_v(2, d | CLEAR_PIN_MASK);
            expect_v(8, ~d & IO_BITS);
            expect_v(9, r & IO_BITS);
            tick();
            wr(0, w, m);
            w = ((p & ~m) | (w & m)) & IO_BITS;
            expect_v(1, w);
            tick();
        end
        p = (~d & w) | ((d | CLEAR_PIN_MASK) & v);
        skew = 8'hFF;
        wr(5, 8'h00);
        tick(3);
        expect_v(0, ~p);
        expect_v(11, ~p);
        tick();
        wr(5, 8'hFF);
        skew = 8'h00;
        wr(3, 8'hFF);
        tick(3);
        expect_v(0, v & CLEAR_PIN_MASK);
        expect_v(11, 8'h00);
        expect_v(8, ~d & IO_BITS);
        tick();
        wr(3, 8'h00);
        // Peripheral with I2C levels owns every pin, open-drain drive
        q = 8'($urandom()) & IO_BITS;
        {ext_en, periph_en, i2c_pad_ctrl, periph_out} = {24'hFFFFFF, q};
        wr(7, 8'hFF);
        tick(3);
        m = ~d & ~q & IO_BITS;
        expect_v(9, q);
        expect_v(8, m);
        expect_v(14, 8'hFF);
        expect_v(0, ~m & v);
        expect_v(11, m | ~v);
        {analog_out_en, cfg_pin_own} = 16'h0330;
        tick(2);
        expect_v(8, m & 8'hCC);
        tick();
        {ext_en, periph_en, i2c_pad_ctrl, analog_out_en, cfg_pin_own} = '0;
        wr(7, 8'h00);
        wr(2, 8'hFF);
        wr(6, r);
        expect_v(6, r);
        expect_v(13, r);
        tick();
        for (int i = 0; i < 4; i++)
        begin
            {master_clear_enable, low_voltage_prog} = 2'(i);
            wr(4, r);
            expect_v(10, r | ((i > 0) ? CLEAR_PIN_MASK : 8'h00));
            tick();
        end
        {master_clear_enable, low_voltage_prog, ext_en, ext_val} = {2'b10, 16'hFF00};
        tick(4);
        expect_v(0, CLEAR_PIN_MASK);
        expect_v(15, 8'h01);
        tick();
        master_clear_enable = 1'b0;
        tick(4);
        expect_v(0, 8'h00);
        expect_v(15, 8'h00);
        tick();
        // Rising edge on pin 0 and falling edge on pin 1 are the only enabled events
        {edge_rise_en, edge_fall_en, ext_val} = 24'h010203;
        tick(3);
        expect_v(12, 8'h01);
        expect_v(15, 8'h02);
        expect_v(0, 8'h03);
        tick();
        expect_v(12, 8'h00);
        ext_val = 8'h00;
        tick(3);
        expect_v(12, 8'h02);
        tick();
        conclude();
    end
endmodule
